// >>> logic/tmz_pkg.sv
// Contract
// R1 - Source select clear: count instruction cycles
// R2 - Count write blocks increments two cycles
// R3 - Source select set: count external edges
// R4 - Edge select: clear rising, set falling
// R5 - Assignment bit routes prescaler timer/watchdog
// R6 - Ratio field picks 1:2 to 1:256
// R7 - Prescaler serves only one consumer
// R8 - Prescaler is hidden eight-bit counter
// R9 - Count writes clear timer-assigned prescaler
// R10 - Watchdog clear clears watchdog-assigned prescaler
// R11 - Reset loads prescaler with zeros
// R12 - Sample source on second, fourth phase
// R13 - Increment lags external edge by sync
// R14 - Undivided input high/low two oscillator periods
// R15 - Divided input period four periods/ratio
// R16 - Timer-to-watchdog switch: clear, clear, write
// R17 - Watchdog-to-timer switch: clear watchdog first
// R18 - Count register readable, writable, eight bits
// R19 - Count wraps to zero, no flag
// R20 - Ratio zero divides by two, doubling
package tmz_pkg;
  localparam logic [11:0] ADDR_TIMER_COUNT = 12'h0004;
  localparam logic [11:0] ADDR_CONTROL_WORD = 12'h0008;
  localparam logic [11:0] ADDR_PORT_C_DIR = 12'h000C;
  localparam logic [11:0] ADDR_STATUS = 12'h0010;
  localparam logic [11:0] ADDR_WDT_CLEAR = 12'h0014;
  localparam logic [7:0] CONTROL_RESET = 8'hFF;
  localparam logic [7:0] PORT_C_DIR_RESET = 8'h3F;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam int BIT_WAKE_DIS = 7;
  localparam int BIT_PULLUP_DIS = 6;
  localparam int BIT_SOURCE = 5;
  localparam int BIT_EDGE = 4;
  localparam int BIT_ASSIGN = 3;
  localparam int RATIO_LSB = 0;
  localparam int RATIO_W = 3;
  localparam logic [1:0] WRITE_INHIBIT = 2'h2;
  localparam int PHASES = 4;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tmz_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tmz_apb_rsp_s;
endpackage : tmz_pkg

// >>> logic/tmz_prescaler.sv
`timescale 1ns/100ps
// Hidden eight-bit divider shared by the timer and the watchdog.
module tmz_prescaler (
  input wire logic clock_i, // core clock
  input wire logic rst_n_i, // synchronised reset, active low
  input wire logic step_i, // one source event to divide
  input wire logic clear_i, // clear counter
  input wire logic [2:0] ratio_i, // division select
  output logic [7:0] count_o, // counter value, internal only
  output logic tap_o // selected divided output
);
  typedef struct packed {
    logic [7:0] cnt;
  } tmz_pre_state_s;

  tmz_pre_state_s state_reg;
  tmz_pre_state_s state_next;

  always_comb
  begin
    state_next = state_reg;
    if (clear_i)
    begin
      state_next.cnt = tmz_pkg::PRESCALE_RESET; // R9 R10
    end
    else if (step_i)
    begin
      state_next.cnt = state_reg.cnt + 8'h01; // R15
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= '{cnt: tmz_pkg::PRESCALE_RESET}; // R11
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Bit n toggles every 2^n events, a symmetrical output.
  assign tap_o = state_reg.cnt[ratio_i]; // R6 R20
  assign count_o = state_reg.cnt;
endmodule : tmz_prescaler

// >>> logic/tmz_timer0.sv
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
// Timer/counter with shared prescaler behind an APB slave.
// Four core clocks form one instruction cycle (phases one to four).
module tmz_timer0 (
  input wire logic clock_i, // 200 MHz core clock
  input wire logic rstn_i, // asynchronous reset, active low
  input wire tmz_pkg::tmz_apb_req_s apb_req_i, // APB request
  output tmz_pkg::tmz_apb_rsp_s apb_rsp_o, // APB answer
  input wire logic external_count_input_i, // external count pin
  output logic [7:0] timer_count_o, // count value
  output logic [1:0] phase_o, // current phase of the cycle
  output logic watchdog_clear_o, // pulse to clear the watchdog
  output logic watchdog_tick_o, // tick toward the watchdog
  output logic [7:0] port_c_direction_o, // port C direction latch
  output logic weak_pullup_disable_o, // control bit 6
  output logic pin_change_wake_disable_o // control bit 7
);
  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] count;
    logic [7:0] ctrl;
    logic [7:0] dir;
    logic [1:0] inhibit;
    logic pin_q;
    logic sync_q2;
    logic sync_q4;
    logic sync_prev;
    logic wdt_clr;
    logic wdt_tick;
    logic [31:0] rdata;
    logic ready;
  } tmz_state_s;

  tmz_state_s state_reg;
  tmz_state_s state_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic pre_step;
  logic pre_clear;
  logic pre_tap;
  logic [7:0] pre_count;
  logic ext_edge;
  logic access;
  logic wr;
  logic count_wr;
  logic wdt_cmd;
  logic to_timer;
  logic inc_src;
  logic cycle_end;
  logic undivided_timer;

  function automatic logic [31:0] widen(input logic [7:0] v);
    widen = {24'h0000_00, v};
  endfunction : widen

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_sync_reg <= 2'b00;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign access = apb_req_i.psel && apb_req_i.penable && state_reg.ready;
  assign wr = access && apb_req_i.pwrite;
  assign count_wr = wr && apb_req_i.paddr == tmz_pkg::ADDR_TIMER_COUNT;
  assign wdt_cmd = wr && apb_req_i.paddr == tmz_pkg::ADDR_WDT_CLEAR;
  assign to_timer = !state_reg.ctrl[tmz_pkg::BIT_ASSIGN]; // R5 R7
  assign cycle_end = state_reg.phase == tmz_pkg::PHASE_Q4;
  // Undivided timer mode steps the count at every cycle end except the two inhibited after a count write.
  assign undivided_timer = !to_timer &&
    !state_reg.ctrl[tmz_pkg::BIT_SOURCE]; // R1 R7

  // Edge on the pin per edge select; input is synchronous to the clock.
  assign ext_edge = state_reg.ctrl[tmz_pkg::BIT_EDGE] ?
    (state_reg.pin_q && !external_count_input_i) :
    (!state_reg.pin_q && external_count_input_i); // R4

  always_comb
  begin
    pre_step = 1'b0;
    if (state_reg.ctrl[tmz_pkg::BIT_SOURCE])
    begin
      pre_step = ext_edge; // R3 R15
    end
    else
    begin
      pre_step = cycle_end; // R1
    end
    if (!to_timer)
    begin
      pre_step = cycle_end;
    end
  end

  assign pre_clear = (count_wr && to_timer) ||
    (wdt_cmd && !to_timer); // R9 R10

  tmz_prescaler u_pre (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .step_i(pre_step),
    .clear_i(pre_clear),
    .ratio_i(state_reg.ctrl[tmz_pkg::RATIO_LSB +: tmz_pkg::RATIO_W]),
    .count_o(pre_count),
    .tap_o(pre_tap)
  ); // R8

  // Source level seen by the synchroniser: prescaler tap or raw path.
  always_comb
  begin
    inc_src = 1'b0;
    if (!to_timer)
    begin
      // Undivided counter mode: raw pin, inverted for falling edges.
      inc_src = state_reg.ctrl[tmz_pkg::BIT_SOURCE] ?
        (external_count_input_i ^ state_reg.ctrl[tmz_pkg::BIT_EDGE]) :
        1'b0; // R4 R7
    end
    else
    begin
      inc_src = pre_tap;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.phase = state_reg.phase + 2'h1;
    state_next.pin_q = external_count_input_i;
    state_next.wdt_clr = wdt_cmd;
    state_next.wdt_tick = !to_timer ? (pre_step && pre_count == 8'hFF) :
      cycle_end; // R7
    state_next.ready = apb_req_i.psel && !apb_req_i.penable;
    if (state_reg.phase == tmz_pkg::PHASE_Q2)
    begin
      state_next.sync_q2 = inc_src; // R12
    end
    if (cycle_end)
    begin
      state_next.sync_q4 = state_reg.sync_q2; // R12
      state_next.sync_prev = state_reg.sync_q4;
      if (state_reg.inhibit != 2'h0)
      begin
        state_next.inhibit = state_reg.inhibit - 2'h1; // R2
      end
      else if (undivided_timer ||
        (state_reg.sync_q4 && !state_reg.sync_prev))
      begin
        state_next.count = state_reg.count + 8'h01; // R13 R19
      end
    end
    if (wr)
    begin
      unique case (apb_req_i.paddr)
        tmz_pkg::ADDR_TIMER_COUNT:
        begin
          state_next.count = apb_req_i.pwdata[7:0]; // R18
          state_next.inhibit = tmz_pkg::WRITE_INHIBIT; // R2
        end
        tmz_pkg::ADDR_CONTROL_WORD:
        begin
          state_next.ctrl = apb_req_i.pwdata[7:0];
        end
        tmz_pkg::ADDR_PORT_C_DIR:
        begin
          state_next.dir = apb_req_i.pwdata[7:0];
        end
        default:
        begin
          state_next.dir = state_reg.dir;
        end
      endcase
    end
    state_next.rdata = 32'h0000_0000;
    if (apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite)
    begin
      unique case (apb_req_i.paddr)
        tmz_pkg::ADDR_TIMER_COUNT:
        begin
          state_next.rdata = widen(state_reg.count); // R18
        end
        tmz_pkg::ADDR_STATUS:
        begin
          state_next.rdata = widen({4'h0, state_reg.inhibit,
            state_reg.phase});
        end
        default:
        begin
          state_next.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '{phase: 2'h0, count: tmz_pkg::COUNT_RESET,
        ctrl: tmz_pkg::CONTROL_RESET, dir: tmz_pkg::PORT_C_DIR_RESET,
        inhibit: 2'h0, pin_q: 1'b0, sync_q2: 1'b0, sync_q4: 1'b0,
        sync_prev: 1'b0, wdt_clr: 1'b0, wdt_tick: 1'b0,
        rdata: 32'h0000_0000, ready: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign apb_rsp_o.pready = state_reg.ready;
  assign apb_rsp_o.pslverr = 1'b0;
  assign apb_rsp_o.prdata = state_reg.rdata;
  assign timer_count_o = state_reg.count;
  assign phase_o = state_reg.phase;
  assign watchdog_clear_o = state_reg.wdt_clr;
  assign watchdog_tick_o = state_reg.wdt_tick;
  assign port_c_direction_o = state_reg.dir;
  assign weak_pullup_disable_o = state_reg.ctrl[tmz_pkg::BIT_PULLUP_DIS];
  assign pin_change_wake_disable_o = state_reg.ctrl[tmz_pkg::BIT_WAKE_DIS];
endmodule : tmz_timer0

// >>> verification/tmz_checker.sv
`timescale 1ns/100ps
module tmz_checker (
  input wire logic clock_i, // clock
  input wire logic rstn_i, // reset
  input wire tmz_pkg::tmz_apb_req_s apb_req_i, // request
  input wire tmz_pkg::tmz_apb_rsp_s apb_rsp_o, // answer
  input wire logic [7:0] timer_count_o, // count
  input wire logic [1:0] phase_o, // phase
  input wire logic watchdog_clear_o // clear pulse
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  wire logic rdy = apb_rsp_o.pready;
  wire logic st = apb_req_i.psel && !apb_req_i.penable;
  wire logic acc = apb_req_i.psel && apb_req_i.penable && rdy;
  wire logic wr = acc && apb_req_i.pwrite;
  wire logic cw = wr && apb_req_i.paddr == tmz_pkg::ADDR_TIMER_COUNT;
  wire logic ww = wr && apb_req_i.paddr == tmz_pkg::ADDR_WDT_CLEAR;
  wire logic [7:0] c = timer_count_o;
  wire logic [7:0] wd = apb_req_i.pwdata[7:0];
  logic cw_reg;
  always_ff @(posedge clock_i or negedge rstn_i)
    if (!rstn_i)
      cw_reg <= 1'b0;
    else
      cw_reg <= cw;
  sequence s_step; $changed(c) && !cw_reg; endsequence
  sequence s_load; cw ##1 1'b1; endsequence
  a_ready_setup: assert property (st |=> rdy)
    else $error("no answer after setup");
  a_ready_pulse: assert property (rdy |=> !rdy)
    else $error("pready too long");
  a_read_upper: assert property (
    acc && !wr |-> apb_rsp_o.prdata[31:8] == '0)
    else $error("upper read bits set");
  a_count_step: assert property (s_step |-> c == $past(c) + 8'h01)
    else $error("count step wrong");
  a_count_phase: assert property (
    s_step |-> $past(phase_o) == tmz_pkg::PHASE_Q4)
    else $error("count moved off fourth phase");
  a_write_load: assert property (cw |=> c == $past(wd))
    else $error("count write lost");
  a_write_hold: assert property (s_load |=> $stable(c) [*6])
    else $error("count moved during inhibit");
  a_wdt_clear: assert property (
    ww |=> watchdog_clear_o ##1 !watchdog_clear_o)
    else $error("watchdog clear pulse wrong");
endmodule : tmz_checker
bind tmz_timer0 tmz_checker i_tmz_checker (.clock_i, .rstn_i, .apb_req_i,
  .apb_rsp_o, .timer_count_o, .phase_o, .watchdog_clear_o);

// >>> verification/tmz_pulse_src.sv
`timescale 1ns/100ps
// Square wave on the count pin; it rests low while stopped.
module tmz_pulse_src #(parameter int HALF = 40) (
  input wire logic clock_i, // clock
  input wire logic en_i, // run
  output logic pin_o // count pin
);
  int n = 0;
  initial pin_o = 1'b0;
  always @(posedge clock_i)
  begin
    n <= en_i ? (n + 1) % HALF : 0;
    if (!en_i)
      pin_o <= 1'b0;
    else if (n == HALF - 1)
      pin_o <= ~pin_o;
  end
endmodule : tmz_pulse_src

// >>> verification/tb_tmz_timer0.sv
`timescale 1ns/100ps
module tb_tmz_timer0;
  localparam logic [11:0] CTL = tmz_pkg::ADDR_CONTROL_WORD;
  localparam logic [11:0] CNT = tmz_pkg::ADDR_TIMER_COUNT;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic en = 1'b0;
  logic pin;
  logic [7:0] cnt;
  logic [7:0] dir;
  logic pu;
  logic wk;
  logic tick;
  logic [31:0] rd;
  tmz_pkg::tmz_apb_req_s req = '0;
  tmz_pkg::tmz_apb_rsp_s rsp;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2.5 clock_i = ~clock_i;
  tmz_timer0 i_tmz_timer0 (.clock_i, .rstn_i, .apb_req_i(req),
    .apb_rsp_o(rsp), .external_count_input_i(pin), .timer_count_o(cnt),
    .phase_o(), .watchdog_clear_o(), .watchdog_tick_o(tick),
    .port_c_direction_o(dir), .weak_pullup_disable_o(pu),
    .pin_change_wake_disable_o(wk));
  tmz_pulse_src i_tmz_pulse_src (.clock_i, .en_i(en), .pin_o(pin));
  always @(posedge clock_i)
    if (++cyc == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  task automatic report_and_stop();
    $display("checks %0d bad %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock_i);
    req.penable <= 1'b1;
    do
      @(posedge clock_i);
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    req <= '0;
    @(posedge clock_i);
  endtask : apb
  task automatic wait_chg(output int n);
    logic [7:0] v;
    v = cnt;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (cnt === v);
  endtask : wait_chg
  task automatic t_regs();
    chk("dir", 32'h0000_003F, dir);
    chk("ctlhi", 32'h0000_0003, {pu, wk});
    apb(1'b0, CTL, '0);
    chk("ctl", '0, rd);
    apb(1'b0, 12'h0FFC, '0);
    chk("hole", '0, rd);
    apb(1'b1, tmz_pkg::ADDR_WDT_CLEAR, '0);
    apb(1'b1, tmz_pkg::ADDR_PORT_C_DIR, 32'h0000_0015);
    chk("dir", 32'h0000_0015, dir);
  endtask : t_regs
  task automatic t_timer();
    int n;
    apb(1'b1, CTL, 32'h0000_000F);
    chk("ctlhi", '0, {pu, wk});
    apb(1'b1, CNT, 32'h0000_00FE);
    apb(1'b0, CNT, '0);
    chk("read", 32'h0000_00FE, rd);
    chk("held", 32'h0000_00FE, cnt);
    repeat (2) wait_chg(n);
    chk("wrap", '0, cnt);
    chk("gap", 4, n);
  endtask : t_timer
  task automatic t_ratio();
    int n;
    int t;
    apb(1'b1, tmz_pkg::ADDR_WDT_CLEAR, '0);
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, CTL, 32'(k));
      repeat (3) wait_chg(n);
      chk("ratio", 8 << k, n);
    end
    t = 0;
    repeat (8)
    begin
      @(posedge clock_i);
      t += tick;
    end
    chk("tick", 2, t);
  endtask : t_ratio
  task automatic t_count();
    for (int e = 0; e < 3; e++)
    begin
      apb(1'b1, tmz_pkg::ADDR_WDT_CLEAR, '0);
      apb(1'b1, CNT, '0);
      apb(1'b1, CTL, (e == 2) ? 32'h0000_0020 :
        32'h0000_0028 + 32'(e * 16));
      apb(1'b1, CNT, '0);
      en <= 1'b1;
      repeat (60) @(posedge clock_i);
      chk("edge", 32'(e != 1), cnt);
      repeat (40) @(posedge clock_i);
      chk("edge", 32'h0000_0001, cnt);
      en <= 1'b0;
    end
  endtask : t_count
  initial
  begin
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_regs();
    t_timer();
    t_ratio();
    t_count();
    report_and_stop();
  end
endmodule : tb_tmz_timer0
